//--- core/sptrc_map.svh
/*
 * Register map, bit positions, reset values and timing counts of the
 * serial port control block.
 * Assumes it is included by bare name by the modules.
 */
`ifndef SPTRC_MAP_SVH
`define SPTRC_MAP_SVH

// apb address width and register byte offsets
`define SPTRC_AW 8
`define SPTRC_OFF_CTRL2 8'h00
`define SPTRC_OFF_STAT1 8'h04
`define SPTRC_OFF_CFG 8'h08
`define SPTRC_OFF_DATA 8'h0C

// serial_control_two bits
`define SPTRC_C2_BRKQ 0
`define SPTRC_C2_STBY 1
`define SPTRC_C2_RXON 2
`define SPTRC_C2_TXEN 3

// serial_status_one bits
`define SPTRC_S1_TXEMPTY 7
`define SPTRC_S1_TXDONE 6
`define SPTRC_S1_RXFULL 5
`define SPTRC_S1_IDLE 4
`define SPTRC_S1_OVERRUN 3
`define SPTRC_S1_FRAMERR 1

// config register width, reset values
`define SPTRC_CFG_W 6
`define SPTRC_CFG_RST 6'h00
`define SPTRC_CHAR_W 9

// bit timing in pclk cycles (a free-running divider times the transmitter; the receiver's own counters restart on each start bit)
`define SPTRC_BIT_CYC 16'h0010
`define SPTRC_HALF_CYC (`SPTRC_BIT_CYC >> 1)
`define SPTRC_IDLE_BITS 16'h000A
`define SPTRC_IDLE_CYC (`SPTRC_BIT_CYC * `SPTRC_IDLE_BITS)

// frame and break lengths in bit times
`define SPTRC_FRM8 4'hA
`define SPTRC_FRM9 4'hB
`define SPTRC_BRK8 4'hA
`define SPTRC_BRK9 4'hB
`define SPTRC_LBRK8 4'hD
`define SPTRC_LBRK9 4'hE

`endif

//--- core/sptrc_pkg.sv
/*
 * Types shared by the serial port control block and its receiver.
 * Assumes nothing beyond the map header.
 */
package sptrc_pkg;
    // transmitter states, one-hot
    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_DATA = 4'h2,
        TX_BREAK = 4'h4,
        TX_FILL = 4'h8
    } sptrc_tx_e;

    // receiver states, one-hot
    typedef enum logic [1:0] {
        RX_WAIT = 2'h1,
        RX_BITS = 2'h2
    } sptrc_rx_e;

    // config register layout, bit 5 down to bit 0
    typedef struct packed {
        logic nine_bit;
        logic wake_mark;
        logic long_break_select;
        logic tx_pin_direction;
        logic rx_source_select;
        logic internal_loop_select;
    } sptrc_cfg_s;

    // one received character
    typedef struct packed {
        logic done;
        logic frame_err;
        logic [8:0] data;
    } sptrc_rxev_s;
endpackage : sptrc_pkg

//--- core/sptrc_rx.sv
/*
 * Receiver shift logic: start detect, mid-bit sampling, stop check
 * and idle-line detection.
 * Assumes line is already synchronised to pclk.
 */
`timescale 1ns/1ps
`include "sptrc_map.svh"
module sptrc_rx (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic line,
    input wire logic nine_bit,
    output sptrc_pkg::sptrc_rxev_s ev,
    output logic idle_det
);
    import sptrc_pkg::*;

    sptrc_rx_e state;
    logic [15:0] cnt;
    logic [3:0] nbits;
    logic [8:0] data;
    logic [15:0] idle_cyc;
    logic armed;
    logic [3:0] last_bit;

    // stop bit index follows the character length
    assign last_bit = nine_bit ? `SPTRC_FRM9 - 4'h1 : `SPTRC_FRM8 - 4'h1;

    // frame reception; disabling drops a partial character
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= RX_WAIT;
            cnt <= 16'h0000;
            nbits <= 4'h0;
            data <= 9'h000;
            ev <= '0;
        end else begin
            ev.done <= 1'b0;
            if (!enable) begin
                state <= RX_WAIT;
            end else begin
                unique case (state)
                    RX_WAIT: begin
                        if (!line) begin
                            state <= RX_BITS;
                            cnt <= `SPTRC_HALF_CYC;
                            nbits <= 4'h0;
                            data <= 9'h000;
                        end
                    end
                    RX_BITS: begin
                        if (cnt != 16'h0000) begin
                            cnt <= cnt - 16'h0001;
                        end else begin
                            cnt <= `SPTRC_BIT_CYC - 16'h0001;
                            nbits <= nbits + 4'h1;
                            if (nbits == 4'h0 && line) begin
                                // glitch, not a start bit
                                state <= RX_WAIT;
                            end else if (nbits == last_bit) begin
                                ev.done <= 1'b1;
                                ev.frame_err <= ~line;
                                ev.data <= data;
                                state <= RX_WAIT;
                            end else if (nbits != 4'h0) begin
                                data[nbits - 4'h1] <= line;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // idle line: ten bit times of ones after activity
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_cyc <= 16'h0000;
            armed <= 1'b0;
            idle_det <= 1'b0;
        end else begin
            idle_det <= 1'b0;
            if (!enable || state != RX_WAIT || !line) begin
                idle_cyc <= 16'h0000;
                if (enable && state == RX_BITS) begin
                    armed <= 1'b1;
                end
            end else if (armed) begin
                idle_cyc <= idle_cyc + 16'h0001;
                if (idle_cyc == `SPTRC_IDLE_CYC - 16'h0001) begin
                    idle_det <= 1'b1;
                    armed <= 1'b0;
                end
            end
        end
    end
endmodule : sptrc_rx

//--- core/sptrc_serial_ctrl.sv
/*
 * Serial port control front end: apb registers, transmitter with
 * queued idle and break, pin ownership, single-wire direction, receiver
 * enable and standby/wakeup, read-only status register.
 * Assumes an apb master on pclk and pin inputs from outside the clock
 * domain; the port mux outside honours the pin ownership outputs.
 */
`timescale 1ns/1ps
`include "sptrc_map.svh"
module sptrc_serial_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`SPTRC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic txd_i,
    output logic txd_o,
    output logic txd_oe,
    output logic tx_pin_owned,
    input wire logic rxd_i,
    output logic rx_pin_owned
);
    import sptrc_pkg::*;

    // address match, used by every decode below
    function automatic logic hit(input logic [`SPTRC_AW-1:0] a,
                                 input logic [`SPTRC_AW-1:0] off);
        return a == off;
    endfunction : hit

    logic acc;
    logic wr;
    logic rd;
    logic mapped;
    logic wr_c2;
    logic wr_cfg;
    logic wr_data;
    logic rd_stat;
    logic rd_data;
    logic transmit_enable;
    logic rx_on;
    logic standby_wakeup_ctrl;
    logic send_break_bit;
    sptrc_cfg_s cfg;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic txd_sync;
    logic rxd_sync;
    logic [15:0] div_cnt;
    logic tick;
    sptrc_tx_e tx_st;
    logic [10:0] sh;
    logic [3:0] bits_left;
    logic [8:0] buf_data;
    logic buf_full;
    logic brk_q;
    logic idle_q;
    logic te_gap;
    logic in_idle;
    logic start_brk;
    logic start_fill;
    logic start_data;
    logic end_chr;
    logic [3:0] brk_len;
    logic [3:0] frm_len;
    logic single_wire;
    logic rx_line;
    sptrc_rxev_s ev;
    logic idle_det;
    logic msb;
    logic wake_hit;
    logic accept;
    logic [8:0] rx_data;
    logic rxfull;
    logic overrun;
    logic framerr;
    logic idle_flag;
    logic st_armed;
    logic clr_seq;
    logic txdone;
    logic [7:0] stat1;

    // apb decode; zero wait states, so pready is simply high
    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;
    assign mapped = hit(paddr, `SPTRC_OFF_CTRL2) | hit(paddr, `SPTRC_OFF_STAT1)
                  | hit(paddr, `SPTRC_OFF_CFG) | hit(paddr, `SPTRC_OFF_DATA);
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;
    assign wr_c2 = wr & hit(paddr, `SPTRC_OFF_CTRL2);
    assign wr_cfg = wr & hit(paddr, `SPTRC_OFF_CFG);
    assign wr_data = wr & hit(paddr, `SPTRC_OFF_DATA);
    assign rd_stat = rd & hit(paddr, `SPTRC_OFF_STAT1);
    assign rd_data = rd & hit(paddr, `SPTRC_OFF_DATA);

    // read data is captured in the setup cycle so it comes from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h0000_0000;
            if (hit(paddr, `SPTRC_OFF_CTRL2)) begin
                prdata[`SPTRC_C2_TXEN] <= transmit_enable;
                prdata[`SPTRC_C2_RXON] <= rx_on;
                prdata[`SPTRC_C2_STBY] <= standby_wakeup_ctrl;
                prdata[`SPTRC_C2_BRKQ] <= send_break_bit;
            end else if (hit(paddr, `SPTRC_OFF_STAT1)) begin
                prdata[7:0] <= stat1;
            end else if (hit(paddr, `SPTRC_OFF_CFG)) begin
                prdata[`SPTRC_CFG_W-1:0] <= cfg;
            end else if (hit(paddr, `SPTRC_OFF_DATA)) begin
                prdata[`SPTRC_CHAR_W-1:0] <= rx_data;
            end
        end
    end

    // control two: enables and break bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transmit_enable <= 1'b0;
            rx_on <= 1'b0;
            send_break_bit <= 1'b0;
        end else if (wr_c2) begin
            transmit_enable <= pwdata[`SPTRC_C2_TXEN];
            rx_on <= pwdata[`SPTRC_C2_RXON];
            send_break_bit <= pwdata[`SPTRC_C2_BRKQ];
        end
    end

    // standby bit; a software write in the wake cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            standby_wakeup_ctrl <= 1'b0;
        end else if (wr_c2) begin
            standby_wakeup_ctrl <= pwdata[`SPTRC_C2_STBY];
        end else if (wake_hit) begin
            standby_wakeup_ctrl <= 1'b0;
        end
    end

    // configuration register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= `SPTRC_CFG_RST;
        end else if (wr_cfg) begin
            cfg <= pwdata[`SPTRC_CFG_W-1:0];
        end
    end

    // two-flop synchronisers for the transmit and receive pins
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_s1[gi] <= 1'b1;
                    pin_s2[gi] <= 1'b1;
                end else begin
                    pin_s1[gi] <= gi == 0 ? txd_i : rxd_i;
                    pin_s2[gi] <= pin_s1[gi];
                end
            end
        end
    endgenerate
    assign txd_sync = pin_s2[0];
    assign rxd_sync = pin_s2[1];

    // free-running bit-time divider; start latency up to one bit
    assign tick = div_cnt == `SPTRC_BIT_CYC - 16'h0001;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 16'h0000;
        end else begin
            div_cnt <= tick ? 16'h0000 : div_cnt + 16'h0001;
        end
    end

    assign brk_len = cfg.long_break_select
                   ? (cfg.nine_bit ? `SPTRC_LBRK9 : `SPTRC_LBRK8)
                   : (cfg.nine_bit ? `SPTRC_BRK9 : `SPTRC_BRK8);
    assign frm_len = cfg.nine_bit ? `SPTRC_FRM9 : `SPTRC_FRM8;

    // queued work starts only between characters; break first, then idle
    assign in_idle = tx_st == TX_IDLE;
    assign start_brk = tick & in_idle & tx_pin_owned & brk_q;
    assign start_fill = tick & in_idle & tx_pin_owned & ~brk_q & idle_q;
    assign start_data = tick & in_idle & tx_pin_owned & ~brk_q & ~idle_q & buf_full;
    assign end_chr = tick & ~in_idle & (bits_left == 4'h1);

    // transmitter sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st <= TX_IDLE;
            sh <= 11'h7FF;
            bits_left <= 4'h0;
        end else if (tick) begin
            unique case (tx_st)
                TX_IDLE: begin
                    if (start_brk) begin
                        tx_st <= TX_BREAK;
                        bits_left <= brk_len;
                    end else if (start_fill) begin
                        tx_st <= TX_FILL;
                        bits_left <= frm_len;
                    end else if (start_data) begin
                        tx_st <= TX_DATA;
                        bits_left <= frm_len;
                        sh <= cfg.nine_bit ? {1'b1, buf_data, 1'b0}
                                           : {2'b11, buf_data[7:0], 1'b0};
                    end
                end
                TX_DATA, TX_BREAK, TX_FILL: begin
                    sh <= {1'b1, sh[10:1]};
                    bits_left <= bits_left - 4'h1;
                    if (bits_left == 4'h1) begin
                        tx_st <= TX_IDLE;
                    end
                end
            endcase
        end
    end

    // transmit buffer; a new write wins over the load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_data <= 9'h000;
            buf_full <= 1'b0;
        end else if (wr_data) begin
            buf_data <= pwdata[`SPTRC_CHAR_W-1:0];
            buf_full <= 1'b1;
        end else if (start_data) begin
            buf_full <= 1'b0;
        end
    end

    // break queue; a new request wins over the start of a break
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brk_q <= 1'b0;
        end else if (wr_c2 && pwdata[`SPTRC_C2_BRKQ] && !send_break_bit) begin
            brk_q <= 1'b1;
        end else if (end_chr && tx_st == TX_BREAK && send_break_bit) begin
            brk_q <= 1'b1;
        end else if (start_brk) begin
            brk_q <= 1'b0;
        end
    end

    // idle queue: enable written low then high during a character
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_q <= 1'b0;
            te_gap <= 1'b0;
        end else begin
            if (wr_c2 && !pwdata[`SPTRC_C2_TXEN] && transmit_enable && !in_idle) begin
                te_gap <= 1'b1;
            end else if (wr_c2 && pwdata[`SPTRC_C2_TXEN] && te_gap) begin
                te_gap <= 1'b0;
            end else if (in_idle && !tx_pin_owned) begin
                te_gap <= 1'b0;
            end
            if (wr_c2 && pwdata[`SPTRC_C2_TXEN] && !transmit_enable && te_gap) begin
                idle_q <= 1'b1;
            end else if (start_fill) begin
                idle_q <= 1'b0;
            end
        end
    end

    // pin ownership outlives the enable until queued work drains
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_pin_owned <= 1'b0;
        end else if (transmit_enable) begin
            tx_pin_owned <= 1'b1;
        end else if (in_idle && !brk_q && !idle_q && !buf_full) begin
            tx_pin_owned <= 1'b0;
        end
    end

    // pin level and enable, registered to avoid glitches on the pin
    assign single_wire = cfg.internal_loop_select & cfg.rx_source_select;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd_o <= 1'b1;
            txd_oe <= 1'b0;
        end else begin
            txd_o <= tx_st == TX_DATA ? sh[0] : tx_st != TX_BREAK;
            txd_oe <= tx_pin_owned & (~single_wire | cfg.tx_pin_direction);
        end
    end

    // receive pin ownership
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_pin_owned <= 1'b0;
        end else begin
            rx_pin_owned <= rx_on & ~cfg.internal_loop_select;
        end
    end

    // receiver source: single wire reads the transmit pin, loop reads txd_o
    assign rx_line = ~cfg.internal_loop_select ? rxd_sync
                   : (cfg.rx_source_select ? txd_sync : txd_o);

    sptrc_rx u_rx (
        .pclk(pclk),
        .presetn(presetn),
        .enable(rx_on),
        .line(rx_line),
        .nine_bit(cfg.nine_bit),
        .ev(ev),
        .idle_det(idle_det)
    );

    assign msb = cfg.nine_bit ? ev.data[8] : ev.data[7];
    assign wake_hit = standby_wakeup_ctrl
                    & (cfg.wake_mark ? (ev.done & msb) : idle_det);
    assign accept = ev.done & (~standby_wakeup_ctrl | (cfg.wake_mark & msb));

    // clear sequence: read status, then read data
    assign clr_seq = rd_data & st_armed;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_armed <= 1'b0;
        end else if (rd_stat) begin
            st_armed <= 1'b1;
        end else if (rd_data) begin
            st_armed <= 1'b0;
        end
    end

    // receive flags; a setting event wins over the clear sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxfull <= 1'b0;
            overrun <= 1'b0;
            framerr <= 1'b0;
            idle_flag <= 1'b0;
        end else begin
            rxfull <= accept | (rxfull & ~clr_seq);
            overrun <= (accept & rxfull) | (overrun & ~clr_seq);
            framerr <= (accept & ev.frame_err) | (framerr & ~clr_seq);
            idle_flag <= (idle_det & ~standby_wakeup_ctrl) | (idle_flag & ~clr_seq);
        end
    end

    // received data; an overrun keeps the older character unless the clear sequence completes in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data <= 9'h000;
        end else if (accept && (!rxfull || clr_seq)) begin
            rx_data <= ev.data;
        end
    end

    assign txdone = in_idle & ~buf_full & ~brk_q & ~idle_q;
    always_comb begin
        stat1 = 8'h00;
        stat1[`SPTRC_S1_TXEMPTY] = ~buf_full;
        stat1[`SPTRC_S1_TXDONE] = txdone;
        stat1[`SPTRC_S1_RXFULL] = rxfull;
        stat1[`SPTRC_S1_IDLE] = idle_flag;
        stat1[`SPTRC_S1_OVERRUN] = overrun;
        stat1[`SPTRC_S1_FRAMERR] = framerr;
    end
endmodule : sptrc_serial_ctrl

//--- testbench/sptrc_ctrl_props.sv
/*
 * Checker bound to the serial port control block.
 * Assumes the map header offsets and one pclk domain.
 */
`timescale 1ns/1ps
`include "sptrc_map.svh"
module sptrc_ctrl_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`SPTRC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    input wire logic txd_o,
    input wire logic txd_oe,
    input wire logic tx_pin_owned,
    input wire logic rx_pin_owned
);
    // access-phase decodes; ownership outputs are two edges behind a write
    wire logic acc = psel && penable;
    wire logic wc2 = acc && pwrite && paddr == `SPTRC_OFF_CTRL2;
    wire logic wcf = acc && pwrite && paddr == `SPTRC_OFF_CFG;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_te_own; wc2 && pwdata[3] |-> ##2 tx_pin_owned; endproperty
    a_te_own: assert property (p_te_own) else $error("enable did not take pin");
    // enable may lag ownership by one edge, so allow the previous cycle
    property p_oe_own; txd_oe |-> tx_pin_owned || $past(tx_pin_owned); endproperty
    a_oe_own: assert property (p_oe_own) else $error("driving unowned pin");
    property p_sw_dir; wcf && pwdata[2:0] == 3'b011 |-> ##2 !txd_oe; endproperty
    a_sw_dir: assert property (p_sw_dir) else $error("single wire still drives");
    property p_rel; $fell(tx_pin_owned) |-> txd_o && $past(txd_o); endproperty
    a_rel: assert property (p_rel) else $error("pin freed mid character");
    property p_rx_off; wc2 && !pwdata[2] |-> ##2 !rx_pin_owned; endproperty
    a_rx_off: assert property (p_rx_off) else $error("rx pin kept when off");
    property p_loop; wcf && pwdata[0] |-> ##2 !rx_pin_owned; endproperty
    a_loop: assert property (p_loop) else $error("rx pin kept in loop");
    property p_st_err; acc && paddr == `SPTRC_OFF_STAT1 |-> !pslverr; endproperty
    a_st_err: assert property (p_st_err) else $error("status access errored");
    property p_unmap; acc && paddr > `SPTRC_OFF_DATA |-> pslverr; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped not refused");
    c_tx: cover property ($fell(txd_o));
    c_rel: cover property ($fell(tx_pin_owned));
    c_rx: cover property ($rose(rx_pin_owned));
endmodule : sptrc_ctrl_props
bind sptrc_serial_ctrl sptrc_ctrl_props sptrc_ctrl_props_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pslverr, .txd_o, .txd_oe, .tx_pin_owned, .rx_pin_owned);

//--- testbench/sptrc_remote_node.sv
/*
 * Remote serial node: sends one 8-bit character, lsb first, when go is high.
 * Assumes the block's bit time; the node itself drives the line high when idle.
 */
`timescale 1ns/1ps
`include "sptrc_map.svh"
module sptrc_remote_node (
    input wire logic pclk,
    input wire logic go,
    input wire logic [7:0] data,
    output logic line
);
    logic [9:0] sh;
    logic busy = 1'b0;
    int bitn = 0;
    int cyc = 0;
    initial line = 1'b1;
    // start, data, stop; each bit held one full bit time
    always @(posedge pclk) begin
        if (!busy && go) begin
            sh <= {1'b1, data, 1'b0};
            busy <= 1'b1;
            bitn <= 0;
            cyc <= 0;
            line <= 1'b0;
        end else if (busy && cyc == `SPTRC_BIT_CYC - 1) begin
            cyc <= 0;
            bitn <= bitn + 1;
            line <= (bitn == 9) ? 1'b1 : sh[bitn + 1];
            busy <= (bitn != 9);
        end else if (busy) begin
            cyc <= cyc + 1;
        end
    end
endmodule : sptrc_remote_node

//--- testbench/sptrc_serial_ctrl_tb.sv
/*
 * Self-checking bench: apb tasks and scenario tasks.
 * Assumes the remote node and the bound checker.
 */
`timescale 1ns/1ps
`include "sptrc_map.svh"
module sptrc_serial_ctrl_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic go = 1'b0;
    logic [7:0] nd = 8'h00;
    logic [31:0] prdata, r;
    logic pready, pslverr, txd_o, txd_oe, tx_pin_owned, rx_pin_owned, rxd_i, e;
    int n_checks = 0;
    int n_mismatch = 0;
    // shared pin has a pull-up when the block lets go of it
    wire logic txd_i = txd_oe ? txd_o : 1'b1;
    // 100 MHz bus clock
    always #5 pclk = ~pclk;
    sptrc_serial_ctrl sptrc_serial_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .txd_i, .txd_o, .txd_oe, .tx_pin_owned, .rxd_i,
        .rx_pin_owned);
    sptrc_remote_node sptrc_remote_node_i (.pclk, .go, .data(nd), .line(rxd_i));
    task chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : chk
    // one apb transfer; holds everything until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wait_fall;
        while (txd_o !== 1'b0) @(posedge pclk);
    endtask : wait_fall
    // samples a frame mid-bit, lsb first, and checks the stop bit
    task get_byte(input logic [7:0] x);
        logic [7:0] v;
        wait_fall;
        repeat (`SPTRC_HALF_CYC) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            repeat (`SPTRC_BIT_CYC) @(posedge pclk);
            v[i] = txd_o;
        end
        repeat (`SPTRC_BIT_CYC) @(posedge pclk);
        chk(v === x && txd_o === 1'b1, "tx frame");
    endtask : get_byte
    task low_len(output int c);
        wait_fall;
        c = 0;
        while (txd_o === 1'b0) begin
            @(posedge pclk);
            c++;
        end
    endtask : low_len
    // 160-cycle frame plus settling
    task node_send(input logic [7:0] x);
        nd <= x;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (200) @(posedge pclk);
    endtask : node_send
    task t_regs;
        logic [31:0] s;
        apb(0, 8'h04, 0);
        s = r;
        apb(1, 8'h04, 32'hFF);
        chk(e === 1'b0, "stat wr err");
        apb(0, 8'h04, 0);
        chk(r === s, "stat changed");
        apb(0, 8'h00, 0);
        chk(r === 32'h0, "ctrl2 reset");
        apb(1, 8'h40, 32'h1);
        chk(e === 1'b1, "unmapped");
        $display("test regs done");
    endtask : t_regs
    task t_tx;
        apb(1, 8'h08, 0);
        apb(1, 8'h00, 32'h08);
        repeat (3) @(posedge pclk);
        chk(tx_pin_owned === 1'b1, "pin not taken");
        // off then on mid character queues an idle, so tx stays busy
        apb(1, 8'h0C, 32'h55);
        wait_fall;
        apb(1, 8'h00, 0);
        apb(1, 8'h00, 32'h08);
        repeat (200) @(posedge pclk);
        apb(0, 8'h04, 0);
        chk(r[6] === 1'b0, "no idle");
        apb(1, 8'h0C, 32'h41);
        get_byte(8'h41);
        apb(1, 8'h0C, 32'hC3);
        fork
            get_byte(8'hC3);
            begin
                apb(1, 8'h00, 32'h00);
                repeat (4) @(posedge pclk);
                chk(tx_pin_owned === 1'b1, "pin dropped");
            end
        join
        repeat (40) @(posedge pclk);
        chk(tx_pin_owned === 1'b0, "pin kept");
        $display("test tx done");
    endtask : t_tx
    // short and long break, eight- and nine-bit characters
    task t_brk;
        logic [7:0] cf [4] = '{8'h00, 8'h08, 8'h20, 8'h28};
        int nb [4] = '{10, 13, 11, 14};
        int c;
        apb(1, 8'h00, 32'h08);
        for (int k = 0; k < 4; k++) begin
            apb(1, 8'h08, {24'h0, cf[k]});
            apb(1, 8'h00, 32'h09);
            fork
                low_len(c);
                apb(1, 8'h00, 32'h08);
            join
            chk(c == nb[k] * `SPTRC_BIT_CYC, "break length");
            repeat (40) @(posedge pclk);
        end
        $display("test break done");
    endtask : t_brk
    task t_rx;
        apb(1, 8'h08, 0);
        apb(1, 8'h00, 32'h04);
        repeat (3) @(posedge pclk);
        chk(rx_pin_owned === 1'b1, "rx pin not taken");
        node_send(8'h5A);
        apb(0, 8'h04, 0);
        chk(r[5] === 1'b1, "rx full");
        apb(0, 8'h0C, 0);
        chk(r[7:0] === 8'h5A, "rx data");
        apb(1, 8'h08, 32'h01);
        repeat (3) @(posedge pclk);
        chk(rx_pin_owned === 1'b0, "loop keeps rx pin");
        $display("test rx done");
    endtask : t_rx
    task t_wake;
        apb(1, 8'h08, 32'h10);
        apb(1, 8'h00, 32'h06);
        node_send(8'h12);
        apb(0, 8'h00, 0);
        chk(r[1] === 1'b1, "standby lost");
        apb(0, 8'h04, 0);
        chk(r[5] === 1'b0, "flag in standby");
        node_send(8'h92);
        apb(0, 8'h00, 0);
        chk(r[1] === 1'b0, "mark no wake");
        apb(0, 8'h0C, 0);
        chk(r[7:0] === 8'h92, "mark char");
        apb(1, 8'h08, 0);
        apb(1, 8'h00, 32'h06);
        node_send(8'h33);
        repeat (200) @(posedge pclk);
        apb(0, 8'h00, 0);
        chk(r[1] === 1'b0, "idle no wake");
        apb(1, 8'h00, 32'h00);
        repeat (3) @(posedge pclk);
        chk(rx_pin_owned === 1'b0, "rx off keeps pin");
        $display("test wake done");
    endtask : t_wake
    task t_wire;
        apb(1, 8'h00, 32'h08);
        apb(1, 8'h08, 32'h03);
        repeat (3) @(posedge pclk);
        chk(txd_oe === 1'b0, "wire receive drives");
        apb(1, 8'h08, 32'h07);
        repeat (3) @(posedge pclk);
        chk(txd_oe === 1'b1, "wire send idle");
        $display("test wire done");
    endtask : t_wire
    task close_out;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out
    // reset, then the scenarios in turn
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_tx;
        t_brk;
        t_rx;
        t_wake;
        t_wire;
        close_out;
    end
    // watchdog, over ten times the expected run
    initial begin
        repeat (40000) @(posedge pclk);
        n_mismatch++;
        close_out;
    end
endmodule : sptrc_serial_ctrl_tb
